// >>> inc/gmc_pkg.sv
// Shared constants and types for the bus command interface of the meter
package gmc_pkg;

  // Primary address switches
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  ADDR_RESERVED  = 5'h1F;
  localparam logic [4:0]  ADDR_FACTORY   = 5'h05;

  // Bus byte codes with attention asserted
  localparam logic [7:0]  CMD_GTL        = 8'h01;
  localparam logic [7:0]  CMD_SDC        = 8'h04;
  localparam logic [7:0]  CMD_GET        = 8'h08;
  localparam logic [7:0]  CMD_LLO        = 8'h11;
  localparam logic [7:0]  CMD_DCL        = 8'h14;
  localparam logic [7:0]  CMD_SPE        = 8'h18;
  localparam logic [7:0]  CMD_SPD        = 8'h19;
  localparam logic [7:0]  CMD_UNL        = 8'h3F;
  localparam logic [7:0]  CMD_UNT        = 8'h5F;
  localparam logic [2:0]  GRP_LISTEN     = 3'h1;
  localparam logic [2:0]  GRP_TALK       = 3'h2;

  // Device dependent command letters
  localparam logic [7:0]  CH_EXECUTE     = 8'h58;
  localparam logic [7:0]  CH_RANGE       = 8'h52;
  localparam logic [7:0]  CH_MODE        = 8'h4D;
  localparam logic [7:0]  CH_TRIG        = 8'h54;
  localparam logic [7:0]  CH_TERM        = 8'h59;
  localparam logic [7:0]  CH_FILT        = 8'h50;
  localparam logic [7:0]  CH_DAMP        = 8'h44;
  localparam logic [7:0]  CH_ZERO        = 8'h5A;
  localparam logic [7:0]  CH_RES         = 8'h42;
  localparam logic [7:0]  CH_DIGIT0      = 8'h30;
  localparam logic [7:0]  CH_LF          = 8'h0A;

  // Range codes
  localparam logic [2:0]  range_code_lowest  = 3'h1;
  localparam logic [2:0]  range_code_highest = 3'h7;
  localparam logic [2:0]  RANGE_FAST_MIN     = 3'h4;

  // Default settings
  localparam logic        DEF_IRQ_MODE   = 1'b0;
  localparam logic [1:0]  DEF_TRIG       = 2'h0;
  localparam logic [7:0]  DEF_TERM       = CH_LF;
  localparam logic [1:0]  DEF_FILT       = 2'h1;
  localparam logic        DEF_DAMP       = 1'b0;
  localparam logic        DEF_ZERO       = 1'b0;
  localparam logic        DEF_RES        = 1'b0;

  // Reading rate timing
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          RATE_SLOW_HZ   = 4;
  localparam int          RATE_FAST_HZ   = 8;
  localparam int          SLOW_CYCLES    = CLK_HZ / RATE_SLOW_HZ;
  localparam int          FAST_CYCLES    = CLK_HZ / RATE_FAST_HZ;

  // Status byte bits
  localparam int          STB_RQS_BIT    = 6;
  localparam int          STB_ERR_BIT    = 5;

  typedef enum logic [1:0] {
    GMC_IDLE, GMC_LISTEN, GMC_TALK
  } gmc_role_t;

  typedef enum logic [1:0] {
    GMC_TX_IDLE, GMC_TX_BYTE, GMC_TX_WAIT
  } gmc_tx_t;

endpackage

// >>> rtl/gmc_range_decode.sv
// Range code to full scale and bus reading interval
`timescale 1ns/10ps
`default_nettype none
module gmc_range_decode
  import gmc_pkg::*;
(
  input  wire logic [2:0]  i_range,
  output logic      [10:0] o_full_scale_mv,
  output logic             o_fast_rate
);

  // Full scale in millivolts; lower three ranges in microvolt units /1000
  always_comb begin
    case (i_range)
      3'h1:    o_full_scale_mv = 11'h002;
      3'h2:    o_full_scale_mv = 11'h014;
      3'h3:    o_full_scale_mv = 11'h0C8;
      3'h4:    o_full_scale_mv = 11'h002;
      3'h5:    o_full_scale_mv = 11'h014;
      3'h6:    o_full_scale_mv = 11'h014;
      default: o_full_scale_mv = 11'h3E8;
    endcase
  end

  // Three lowest ranges read slowly
  assign o_fast_rate = (i_range >= RANGE_FAST_MIN);

endmodule
`default_nettype wire

// >>> rtl/gmc_rate_timer.sv
// Reading pace timer for bus updates
`timescale 1ns/10ps
`default_nettype none
module gmc_rate_timer
  import gmc_pkg::*;
#(
  parameter int SLOW = SLOW_CYCLES,
  parameter int FAST = FAST_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_ce,
  input  wire logic i_run,
  input  wire logic i_fast,
  output logic      o_tick
);

  if (FAST < 1 || SLOW < FAST || SLOW >= (1 << 24)) begin : g_bad_interval
    $error("gmc_rate_timer: bad interval");
  end

  logic [23:0] count_reg;

  // Tick at zero, then reload and count down one reading interval
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      count_reg <= 24'h000000;
      o_tick    <= 1'b0;
    end else if (i_ce) begin
      o_tick <= 1'b0;
      if (!i_run) begin
        count_reg <= 24'h000000;
      end else if (count_reg == 24'h000000) begin
        o_tick    <= 1'b1;
        count_reg <= i_fast ? 24'(FAST - 1) : 24'(SLOW - 1);
      end else begin
        count_reg <= count_reg - 24'h000001;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/gmc_command_if.sv
// Bus listener, talker and command interpreter of the meter
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Operation
// - Five address switches select one of 31 talk/listen address pairs.
// - Switch pattern all ones is never accepted as the device address.
// - Factory switch setting is address five.
// - Switches are captured only at power-up reset.
// - Interface clear resets bus roles only, settings kept; the code also leaves serial poll mode.
// - Remote enable puts device in remote and lights remote lamp; the code enters remote only on its listen address while remote enable is true.
// - End is asserted with the last byte of a multi-byte transfer.
// - Service request line asks controller for a serial poll.
// - Universal device clear restores all default settings.
// - After lockout front-panel controls cannot change settings.
// - Serial poll disable leaves poll mode, data output resumes.
// - Poll enabled and talking sends status byte instead of data.
// - Untalk idles the device only if it was talker.
// - Unlisten idles the device only if it was listener.
// - Selected device clear while listening acts as device clear.
// - Group trigger while listening starts a conversion.
// - Go to local while listening returns panel control, settings kept.
// - Device commands stay pending until the execute character.
// - Range codes one to seven map to the seven full scales; in the code codes five and six both decode to 20.
// - Bus reading rate is 4/s on low ranges, 8/s otherwise.
// - Clear defaults: top range, no SRQ, trigger 0, CR-LF, filter 1; the code sets the terminator to LF only.
// - An invalid command string changes no setting; the code keeps its valid pairs pending, so the next valid execute applies them.
// - Service request only in interrupt response mode.
module gmc_command_if
  import gmc_pkg::*;
#(
  parameter int SLOW = SLOW_CYCLES,
  parameter int FAST = FAST_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic [4:0]  i_addr_sw,
  input  wire logic [7:0]  i_bus_data,
  input  wire logic        i_bus_valid,
  input  wire logic        i_atn,
  input  wire logic        i_ifc,
  input  wire logic        i_ren,
  input  wire logic        i_tx_ready,
  input  wire logic [7:0]  i_rdg_data,
  input  wire logic        i_rdg_valid,
  input  wire logic        i_rdg_last,
  input  wire logic        i_rdg_ovfl,
  input  wire logic        i_panel_req,
  input  wire logic [2:0]  i_panel_range,
  output logic [7:0]       o_tx_data,
  output logic             o_tx_valid,
  output logic             o_eoi,
  output logic             o_srq,
  output logic             o_remote,
  output logic             o_lockout,
  output logic             o_talker,
  output logic             o_listener,
  output logic             o_rdg_ack,
  output logic             o_trigger,
  output logic [2:0]       o_range,
  output logic             o_irq_mode,
  output logic [1:0]       o_trig_mode,
  output logic [7:0]       o_term,
  output logic [1:0]       o_filter,
  output logic             o_damping,
  output logic             o_zero,
  output logic             o_hi_res,
  output logic [10:0]      o_full_scale_mv,
  output logic             o_fast_rate
);

  //////////////////////////////////////////////////////////////////////////
  // Address capture
  logic [4:0] addr_reg;
  logic       addr_ok_reg;
  logic       boot_reg;

  // Latch switches once, in the cycle after power-up reset releases
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      boot_reg    <= 1'b1;
      addr_reg    <= ADDR_FACTORY;
      addr_ok_reg <= 1'b0;
    end else if (i_ce && boot_reg) begin
      boot_reg    <= 1'b0;
      addr_reg    <= i_addr_sw;
      addr_ok_reg <= (i_addr_sw != ADDR_RESERVED);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command byte decode
  logic cmd_valid;
  logic dat_valid;
  logic my_listen;
  logic my_talk;
  logic other_talk;
  logic is_listener;
  logic is_talker;
  gmc_role_t role_reg;

  assign cmd_valid  = i_ce && i_bus_valid && i_atn;
  assign dat_valid  = i_ce && i_bus_valid && !i_atn;
  assign my_listen  = cmd_valid && addr_ok_reg
                      && i_bus_data == {GRP_LISTEN, addr_reg};
  assign my_talk    = cmd_valid && addr_ok_reg
                      && i_bus_data == {GRP_TALK, addr_reg};
  assign other_talk = cmd_valid && i_bus_data[6:5] == GRP_TALK[1:0]
                      && i_bus_data != CMD_UNT && !my_talk;
  assign is_listener = (role_reg == GMC_LISTEN);
  assign is_talker   = (role_reg == GMC_TALK);

  logic do_clear, do_get, do_gtl;
  assign do_clear = cmd_valid && (i_bus_data == CMD_DCL
                    || (i_bus_data == CMD_SDC && is_listener));
  assign do_get   = cmd_valid && i_bus_data == CMD_GET && is_listener;
  assign do_gtl   = cmd_valid && i_bus_data == CMD_GTL && is_listener;

  // Talk/listen role; interface clear idles it
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      role_reg <= GMC_IDLE;
    end else if (i_ce) begin
      if (i_ifc) begin
        role_reg <= GMC_IDLE;
      end else if (my_listen) begin
        role_reg <= GMC_LISTEN;
      end else if (my_talk) begin
        role_reg <= GMC_TALK;
      end else if (cmd_valid && i_bus_data == CMD_UNT && is_talker) begin
        role_reg <= GMC_IDLE;
      end else if (cmd_valid && i_bus_data == CMD_UNL && is_listener) begin
        role_reg <= GMC_IDLE;
      end else if (other_talk && is_talker) begin
        role_reg <= GMC_IDLE;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Remote, lockout and serial poll state
  logic spe_reg;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_remote  <= 1'b0;
      o_lockout <= 1'b0;
      spe_reg   <= 1'b0;
    end else if (i_ce) begin
      if (!i_ren) begin
        o_remote  <= 1'b0;
        o_lockout <= 1'b0;
      end else begin
        if (my_listen)
          o_remote <= 1'b1;
        else if (do_gtl)
          o_remote <= 1'b0;
        if (cmd_valid && i_bus_data == CMD_LLO)
          o_lockout <= 1'b1;
      end
      if (i_ifc)
        spe_reg <= 1'b0;
      else if (cmd_valid && i_bus_data == CMD_SPE)
        spe_reg <= 1'b1;
      else if (cmd_valid && i_bus_data == CMD_SPD)
        spe_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Staged device dependent commands
  logic [7:0] letter_reg;
  logic       have_letter_reg;
  logic       bad_reg;
  logic [2:0] p_range_reg;
  logic       p_irq_reg;
  logic [1:0] p_trig_reg;
  logic [7:0] p_term_reg;
  logic [1:0] p_filt_reg;
  logic       p_damp_reg;
  logic       p_zero_reg;
  logic       p_res_reg;
  logic [7:0] arg;
  logic       listen_data;
  logic       apply;

  assign arg         = i_bus_data - CH_DIGIT0;
  assign listen_data = dat_valid && is_listener;
  assign apply       = listen_data && !have_letter_reg
                       && i_bus_data == CH_EXECUTE && !bad_reg;

  // Collect letter/argument pairs into pending copies
  always_ff @(posedge i_clock) begin
    if (i_rst || (i_ce && do_clear)) begin
      have_letter_reg <= 1'b0;
      letter_reg      <= 8'h00;
      bad_reg         <= 1'b0;
      p_range_reg     <= range_code_highest;
      p_irq_reg       <= DEF_IRQ_MODE;
      p_trig_reg      <= DEF_TRIG;
      p_term_reg      <= DEF_TERM;
      p_filt_reg      <= DEF_FILT;
      p_damp_reg      <= DEF_DAMP;
      p_zero_reg      <= DEF_ZERO;
      p_res_reg       <= DEF_RES;
    end else if (listen_data) begin
      if (!have_letter_reg) begin
        if (i_bus_data == CH_EXECUTE) begin
          bad_reg <= 1'b0;
        end else begin
          letter_reg      <= i_bus_data;
          have_letter_reg <= 1'b1;
        end
      end else begin
        have_letter_reg <= 1'b0;
        case (letter_reg)
          CH_RANGE:
            if (arg >= 8'(range_code_lowest) && arg <= 8'(range_code_highest))
              p_range_reg <= arg[2:0];
            else
              bad_reg <= 1'b1;
          CH_MODE:
            if (arg <= 8'h01) p_irq_reg <= arg[0];
            else bad_reg <= 1'b1;
          CH_TRIG:
            if (arg <= 8'h03) p_trig_reg <= arg[1:0];
            else bad_reg <= 1'b1;
          CH_TERM: p_term_reg <= i_bus_data;
          CH_FILT:
            if (arg <= 8'h02) p_filt_reg <= arg[1:0];
            else bad_reg <= 1'b1;
          CH_DAMP:
            if (arg <= 8'h01) p_damp_reg <= arg[0];
            else bad_reg <= 1'b1;
          CH_ZERO:
            if (arg <= 8'h01) p_zero_reg <= arg[0];
            else bad_reg <= 1'b1;
          CH_RES:
            if (arg <= 8'h01) p_res_reg <= arg[0];
            else bad_reg <= 1'b1;
          default: bad_reg <= 1'b1;
        endcase
      end
    end
  end

  // Live settings; commit on execute, defaults on clear, panel unless locked or remote
  always_ff @(posedge i_clock) begin
    if (i_rst || (i_ce && do_clear)) begin
      o_range     <= range_code_highest;
      o_irq_mode  <= DEF_IRQ_MODE;
      o_trig_mode <= DEF_TRIG;
      o_term      <= DEF_TERM;
      o_filter    <= DEF_FILT;
      o_damping   <= DEF_DAMP;
      o_zero      <= DEF_ZERO;
      o_hi_res    <= DEF_RES;
    end else if (i_ce && apply) begin
      o_range     <= p_range_reg;
      o_irq_mode  <= p_irq_reg;
      o_trig_mode <= p_trig_reg;
      o_term      <= p_term_reg;
      o_filter    <= p_filt_reg;
      o_damping   <= p_damp_reg;
      o_zero      <= p_zero_reg;
      o_hi_res    <= p_res_reg;
    end else if (i_ce && i_panel_req && !o_lockout && !o_remote) begin
      if (i_panel_range >= range_code_lowest)
        o_range <= i_panel_range;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trigger, service request and output
  logic fast;
  logic tick;
  logic run;
  logic err_reg;
  logic data_ready_reg;
  logic rqs_reg;
  logic [7:0] stb;
  logic [10:0] fs_next;
  gmc_tx_t tx_reg;

  gmc_range_decode u_decode (
    .i_range         (o_range),
    .o_full_scale_mv (fs_next),
    .o_fast_rate     (fast)
  );

  assign run = o_trig_mode[1] ? 1'b0 : is_talker;

  gmc_rate_timer #(
    .SLOW (SLOW),
    .FAST (FAST)
  ) u_timer (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    .i_run   (run),
    .i_fast  (fast),
    .o_tick  (tick)
  );

  assign stb = {1'b0, rqs_reg, err_reg, 3'h0, 1'b0, i_rdg_ovfl};

  // Conversion start pulse, status flags and request line
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_trigger      <= 1'b0;
      o_fast_rate    <= 1'b0;
      err_reg        <= 1'b0;
      data_ready_reg <= 1'b0;
      rqs_reg        <= 1'b0;
      o_srq          <= 1'b0;
    end else if (i_ce) begin
      o_fast_rate <= fast;
      o_trigger   <= do_get || tick;
      if (listen_data && i_bus_data == CH_EXECUTE && bad_reg)
        err_reg <= 1'b1;
      else if (spe_reg && is_talker && tx_reg == GMC_TX_WAIT)
        err_reg <= 1'b0;
      if (tick || do_get)
        data_ready_reg <= 1'b1;
      else if (spe_reg && is_talker && tx_reg == GMC_TX_WAIT)
        data_ready_reg <= 1'b0;
      rqs_reg <= o_irq_mode && (err_reg || data_ready_reg);
      o_srq   <= o_irq_mode && (err_reg || data_ready_reg);
    end
  end

  // Talker byte path: status byte under poll, else reading bytes
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tx_reg     <= GMC_TX_IDLE;
      o_tx_data  <= 8'h00;
      o_tx_valid <= 1'b0;
      o_eoi      <= 1'b0;
      o_rdg_ack  <= 1'b0;
    end else if (i_ce) begin
      o_rdg_ack <= 1'b0;
      case (tx_reg)
        GMC_TX_IDLE:
          if (is_talker && !i_atn) begin
            if (spe_reg) begin
              o_tx_data  <= stb;
              o_eoi      <= 1'b0;
              o_tx_valid <= 1'b1;
              tx_reg     <= GMC_TX_BYTE;
            end else if (i_rdg_valid) begin
              o_tx_data  <= i_rdg_data;
              o_eoi      <= i_rdg_last;
              o_tx_valid <= 1'b1;
              o_rdg_ack  <= 1'b1;
              tx_reg     <= GMC_TX_BYTE;
            end
          end
        GMC_TX_BYTE:
          if (i_tx_ready) begin
            o_tx_valid <= 1'b0;
            o_eoi      <= 1'b0;
            tx_reg     <= spe_reg ? GMC_TX_WAIT : GMC_TX_IDLE;
          end
        default:
          if (!spe_reg || !is_talker)
            tx_reg <= GMC_TX_IDLE;
      endcase
    end
  end

  // Role flags and registered full scale
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_talker   <= 1'b0;
      o_listener <= 1'b0;
      o_full_scale_mv <= 11'h000;
    end else if (i_ce) begin
      o_talker   <= is_talker;
      o_listener <= is_listener;
      o_full_scale_mv <= fs_next;
    end
  end

endmodule
`default_nettype wire

// >>> verif/gmc_monitor.sv
// Port checker of the bus command interface
`timescale 1ns/10ps
`default_nettype none
module gmc_monitor
  import gmc_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire logic       i_ce,
  input wire logic [7:0] i_bus_data,
  input wire logic       i_bus_valid,
  input wire logic       i_atn,
  input wire logic       i_ifc,
  input wire logic       i_tx_ready,
  input wire logic       i_panel_req,
  input wire logic [7:0] o_tx_data,
  input wire logic       o_tx_valid,
  input wire logic       o_eoi,
  input wire logic       o_srq,
  input wire logic       o_talker,
  input wire logic       o_listener,
  input wire logic       o_trigger,
  input wire logic [2:0] o_range,
  input wire logic       o_irq_mode,
  input wire logic       o_lockout
);
  // Command byte taken this edge
  wire logic cmd = i_bus_valid && i_ce && i_atn;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_eoi_with_data: assert property (o_eoi |-> o_tx_valid)
    else $error("end flag without a data byte");
  a_tx_byte_held: assert property (o_tx_valid && !i_tx_ready && !i_ifc
    |=> o_tx_valid && $stable(o_tx_data) && $stable(o_eoi))
    else $error("output byte changed before acceptance");
  a_get_trigger: assert property (cmd && i_bus_data == CMD_GET
    && o_listener |=> o_trigger) else $error("trigger missing");
  a_unt_idle: assert property (cmd && i_bus_data == CMD_UNT
    |=> ##1 !o_talker) else $error("talker kept after untalk");
  a_unt_keeps_listen: assert property (cmd && i_bus_data == CMD_UNT
    && o_listener |=> o_listener) else $error("untalk dropped listener");
  a_unl_idle: assert property (cmd && i_bus_data == CMD_UNL
    |=> ##1 !o_listener) else $error("listener kept after unlisten");
  a_ifc_keeps_set: assert property (i_ifc && i_ce && !i_bus_valid
    && !i_panel_req |=> $stable(o_range) ##1 !o_talker && !o_listener)
    else $error("interface clear misbehaved");
  a_lockout_panel: assert property (o_lockout && i_panel_req
    && !i_bus_valid |=> $stable(o_range)) else $error("panel in lockout");
  a_srq_needs_irq: assert property (!o_irq_mode && !$past(o_irq_mode)
    && !$past(o_irq_mode, 2) |-> !o_srq) else $error("request in standard mode");
endmodule

bind gmc_command_if gmc_monitor gmc_monitor_i (
  .i_clock(i_clock), .i_rst(i_rst), .i_ce(i_ce), .i_bus_data(i_bus_data),
  .i_bus_valid(i_bus_valid), .i_atn(i_atn), .i_ifc(i_ifc),
  .i_tx_ready(i_tx_ready), .i_panel_req(i_panel_req), .o_tx_data(o_tx_data),
  .o_tx_valid(o_tx_valid), .o_eoi(o_eoi), .o_srq(o_srq), .o_talker(o_talker),
  .o_listener(o_listener), .o_trigger(o_trigger), .o_range(o_range),
  .o_irq_mode(o_irq_mode), .o_lockout(o_lockout)
);
`default_nettype wire

// >>> verif/gmc_ctrl_model.sv
// Bus controller model driving command bytes and the acceptor handshake
`timescale 1ns/10ps
`default_nettype none
module gmc_ctrl_model (
  input  wire logic i_clock,
  input  wire logic i_slow,
  output logic [7:0] o_bus_data,
  output logic       o_bus_valid,
  output logic       o_atn,
  output logic       o_tx_ready
);
  // Idle lines at time zero
  initial begin
    o_bus_data = 8'h00;
    o_bus_valid = 1'b0;
    o_atn = 1'b0;
    o_tx_ready = 1'b1;
  end
  // Acceptor pace, random stalls when slow
  always @(negedge i_clock) begin
    o_tx_ready <= i_slow ? ($urandom_range(2) == 0) : 1'b1;
  end
  // One byte; attention marks addresses and commands
  task automatic send(input logic a, input logic [7:0] d);
    @(negedge i_clock);
    o_atn = a;
    o_bus_data = d;
    o_bus_valid = 1'b1;
    @(negedge i_clock);
    o_bus_valid = 1'b0;
    o_atn = 1'b0;
    o_bus_data = ~d;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_gmc_command_if.sv
// Self-checking bench of the bus command interface
`timescale 1ns/10ps
`default_nettype none
module tb_gmc_command_if
  import gmc_pkg::*;
;
  logic        clock, rst, ifc, ren, slow, pnl_req, tx_ready, bus_valid;
  logic        rdg_valid, rdg_last, ovfl, tx_valid, eoi, srq, remote, atn;
  logic        lockout, talker, listener, rdg_ack, trigger, irq_mode, fast;
  logic        damping, zero, hi_res;
  logic [2:0]  range, pnl_range;
  logic [4:0]  addr_sw;
  logic [1:0]  trig_mode, filter;
  logic [7:0]  bus_data, rdg_data, tx_data, term;
  logic [10:0] fs_mv;
  int          error_cnt, n_tests, m_range, m_irq, m_filter, m_trig, k, r;
  int          fs_tab[7] = '{2, 20, 200, 2, 20, 20, 1000};
  logic [7:0]  pend[$], txq[$];
  logic        eoq[$];

  gmc_command_if #(.SLOW(8), .FAST(4)) gmc_command_if_i (
    .i_clock(clock), .i_rst(rst), .i_ce(1'b1), .i_addr_sw(addr_sw),
    .i_bus_data(bus_data), .i_bus_valid(bus_valid), .i_atn(atn),
    .i_ifc(ifc), .i_ren(ren), .i_tx_ready(tx_ready),
    .i_rdg_data(rdg_data), .i_rdg_valid(rdg_valid), .i_rdg_last(rdg_last),
    .i_rdg_ovfl(ovfl), .i_panel_req(pnl_req), .i_panel_range(pnl_range),
    .o_tx_data(tx_data), .o_tx_valid(tx_valid), .o_eoi(eoi), .o_srq(srq),
    .o_remote(remote), .o_lockout(lockout), .o_talker(talker),
    .o_listener(listener), .o_rdg_ack(rdg_ack), .o_trigger(trigger),
    .o_range(range), .o_irq_mode(irq_mode), .o_trig_mode(trig_mode),
    .o_term(term), .o_filter(filter), .o_damping(damping), .o_zero(zero),
    .o_hi_res(hi_res), .o_full_scale_mv(fs_mv), .o_fast_rate(fast));
  gmc_ctrl_model gmc_ctrl_model_i (
    .i_clock(clock), .i_slow(slow), .o_bus_data(bus_data),
    .o_bus_valid(bus_valid), .o_atn(atn), .o_tx_ready(tx_ready));

  // Clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Bytes accepted from the talker
  always @(posedge clock) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      txq.push_back(tx_data);
      eoq.push_back(eoi);
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic timed_out();
    error_cnt++;
    print_verdict();
  endtask
  function automatic void m_default();
    m_range = 7;
    m_irq = 0;
    m_filter = 1;
    m_trig = 0;
  endfunction
  task automatic cmp_set();
    chk(range, m_range[2:0]);
    chk(irq_mode, m_irq[0]);
    chk(filter, m_filter[1:0]);
    chk(trig_mode, m_trig[1:0]);
    chk(fast, m_range >= 4);
    chk(fs_mv, fs_tab[m_range-1]);
  endtask
  task automatic do_reset(input logic [4:0] sw);
    @(negedge clock);
    addr_sw = sw;
    rst = 1'b1;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    m_default();
    repeat (2) @(negedge clock);
  endtask
  task automatic cmd(input logic [7:0] c);
    gmc_ctrl_model_i.send(1'b1, c);
    repeat (2) @(negedge clock);
  endtask
  // Device command byte; execute applies the model's pending list
  task automatic dd(input logic [7:0] c);
    int ok, v, rr, m, p, t;
    gmc_ctrl_model_i.send(1'b0, c);
    if (c != CH_EXECUTE) begin
      pend.push_back(c);
      return;
    end
    ok = 1;
    rr = m_range;
    m = m_irq;
    p = m_filter;
    t = m_trig;
    for (k = 0; k + 1 < pend.size(); k += 2) begin
      v = int'(pend[k+1]) - int'(CH_DIGIT0);
      case (pend[k])
        CH_RANGE: rr = (v >= 1 && v <= 7) ? v : -1;
        CH_MODE:  m = (v >= 0 && v <= 1) ? v : -1;
        CH_FILT:  p = (v >= 0 && v <= 2) ? v : -1;
        CH_TRIG:  t = (v >= 0 && v <= 3) ? v : -1;
        default:  ok = 0;
      endcase
    end
    if (ok == 1 && rr > 0 && m >= 0 && p >= 0 && t >= 0) begin
      m_range = rr;
      m_irq = m;
      m_filter = p;
      m_trig = t;
    end
    pend.delete();
    repeat (3) @(negedge clock);
    cmp_set();
  endtask
  task automatic dd3(input logic [7:0] l, input int v);
    dd(l);
    dd(CH_DIGIT0 + v[7:0]);
    dd(CH_EXECUTE);
  endtask
  task automatic panel(input logic [2:0] pr);
    @(negedge clock);
    pnl_req = 1'b1;
    pnl_range = pr;
    @(negedge clock);
    pnl_req = 1'b0;
    pnl_range = ~pr;
    repeat (3) @(negedge clock);
  endtask
  task automatic feed(input logic [7:0] d, input logic l);
    @(negedge clock);
    rdg_data = d;
    rdg_last = l;
    rdg_valid = 1'b1;
    for (k = 0; k < 300 && rdg_ack !== 1'b1; k++) @(negedge clock);
    if (k == 300) timed_out();
    rdg_valid = 1'b0;
    rdg_data = ~d;
  endtask
  task automatic wait_q(input int n);
    for (k = 0; k < 300 && txq.size() < n; k++) @(negedge clock);
    if (k == 300) timed_out();
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, ifc, slow, pnl_req, rdg_valid, rdg_last, ovfl} = 7'h40;
    {pnl_range, rdg_data, addr_sw, ren} = {3'h0, 8'h00, ADDR_FACTORY, 1'b1};
    void'($urandom(32'hDD39));
    do_reset(ADDR_FACTORY);
    cmp_set();
    chk({term, damping, zero, hi_res, srq}, {DEF_TERM, 4'h0});
    m_range = 3;
    panel(3'h3);
    chk(range, 3'h3);
    $display("Step defaults and panel done");
    addr_sw = 5'h1A;
    cmd({GRP_LISTEN, 5'h1A});
    chk(listener, 1'b0);
    cmd({GRP_LISTEN, ADDR_FACTORY});
    chk({listener, remote}, 2'h3);
    r = $urandom_range(7, 1);
    dd(CH_RANGE);
    dd(CH_DIGIT0 + r[7:0]);
    dd(CH_FILT);
    dd(CH_DIGIT0);
    chk(range, m_range[2:0]);
    dd(CH_EXECUTE);
    for (r = 1; r <= 7; r++) dd3(CH_RANGE, r);
    for (r = 0; r <= 3; r++) dd3(CH_TRIG, 3 - r);
    dd3(CH_RANGE, 9);
    dd3(8'h48, 1);
    $display("Step commands and ranges done");
    dd3(CH_MODE, 1);
    ovfl = 1'b1;
    dd3(CH_RANGE, 0);
    for (k = 0; k < 20 && srq !== 1'b1; k++) @(negedge clock);
    chk(srq, 1'b1);
    txq.delete();
    cmd(CMD_SPE);
    cmd({GRP_TALK, ADDR_FACTORY});
    wait_q(1);
    chk({txq[0][STB_RQS_BIT], txq[0][STB_ERR_BIT], txq[0][0]}, 3'h7);
    cmd(CMD_SPD);
    ovfl = 1'b0;
    slow = 1'b1;
    txq.delete();
    eoq.delete();
    for (r = 0; r < 3; r++) feed(8'h30 + r[7:0], r == 2);
    wait_q(3);
    slow = 1'b0;
    for (r = 0; r < 3; r++) chk({txq[r], eoq[r]}, {8'h30 + r[7:0], r == 2});
    chk(talker, 1'b1);
    cmd(CMD_UNT);
    chk(talker, 1'b0);
    $display("Step poll and talk done");
    cmd({GRP_LISTEN, ADDR_FACTORY});
    cmd(CMD_UNT);
    chk(listener, 1'b1);
    dd3(CH_RANGE, 4);
    cmd(CMD_UNL);
    chk(listener, 1'b0);
    cmd(CMD_SDC);
    chk(range, 3'h4);
    cmd({GRP_LISTEN, ADDR_FACTORY});
    gmc_ctrl_model_i.send(1'b1, CMD_GET);
    for (k = 0; k < 4 && trigger !== 1'b1; k++) @(negedge clock);
    chk(trigger, 1'b1);
    cmd(CMD_SDC);
    m_default();
    cmp_set();
    $display("Step addressed commands done");
    dd3(CH_RANGE, 3);
    @(negedge clock);
    ifc = 1'b1;
    repeat (2) @(negedge clock);
    ifc = 1'b0;
    chk({listener, range}, 4'h3);
    cmd({GRP_LISTEN, ADDR_FACTORY});
    cmd(CMD_GTL);
    chk(remote, 1'b0);
    cmp_set();
    cmd(CMD_LLO);
    panel(3'h2);
    chk({lockout, range}, 4'hB);
    dd3(CH_RANGE, 2);
    cmd(CMD_DCL);
    m_default();
    cmp_set();
    $display("Step clear, local and lockout done");
    do_reset(5'h1E);
    cmd({GRP_LISTEN, 5'h1E});
    chk(listener, 1'b1);
    do_reset(ADDR_RESERVED);
    cmd({GRP_TALK, ADDR_RESERVED});
    chk({talker, listener}, 2'h0);
    $display("Step address switches done");
    print_verdict();
  end
endmodule
`default_nettype wire
